// File: include/ues_pkg.sv
`default_nettype none
package ues_pkg;
    // Bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    // Event vector spans interrupt-enable bit positions 0..22
    localparam int unsigned EVT_W = 23;
    localparam int unsigned EVT_IDX_W = 5;
    localparam int unsigned CNT_W = 16;

    // Register offsets (byte addresses)
    localparam logic [11:0] EVT_BASE_OFF   = 12'h100;
    localparam logic [11:0] TX_BEGUN_OFF   = 12'h150;
    localparam logic [11:0] TX_HALTED_OFF  = 12'h158;
    localparam logic [11:0] SHORTCUTS_OFF  = 12'h200;
    localparam logic [11:0] INT_ENABLE_OFF = 12'h300;
    localparam logic [11:0] INT_STATUS_OFF = 12'h380;
    localparam logic [11:0] FILL_COUNT_OFF = 12'h384;

    // Event bit positions, shared by event flags, enable mask and status
    localparam int unsigned EV_CTS_ACT   = 0;
    localparam int unsigned EV_CTS_DEACT = 1;
    localparam int unsigned EV_RX_BYTE   = 2;
    localparam int unsigned EV_RX_FULL   = 4;
    localparam int unsigned EV_TX_BYTE   = 7;
    localparam int unsigned EV_TX_LAST   = 8;
    localparam int unsigned EV_ERROR     = 9;
    localparam int unsigned EV_RX_TMO    = 17;
    localparam int unsigned EV_RX_START  = 19;
    localparam int unsigned EV_TX_START  = 20;
    localparam int unsigned EV_TX_HALT   = 22;
    localparam logic [22:0] EVT_VALID    = 23'h5a_0397;

    // Shortcut bit positions
    localparam int unsigned SC_RESTART = 5;
    localparam int unsigned SC_STOP    = 6;
    localparam logic [31:0] SC_VALID   = 32'h0000_0060;

    // Reset values
    localparam logic [22:0] EVT_RST    = 23'h00_0000;
    localparam logic [31:0] SC_RST     = 32'h0000_0000;
    localparam logic [22:0] INTERRUPT_ENABLE_MASK_RST  = 23'h00_0000;
    localparam logic [15:0] CNT_RST    = 16'h0000;
endpackage : ues_pkg
`default_nettype wire

// File: hdl/ues_tx_detect.sv
`timescale 1ns/10ps
`default_nettype none
module ues_tx_detect (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Transmitter activity level from the serial engine
    input  wire logic tx_active,
    // One-cycle event pulses
    output logic      transmitter_started,
    output logic      transmitter_halted
);
    logic active_prev_reg;   // Activity seen one cycle earlier

    // Remember the previous activity level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_prev_reg <= 1'b0;
        end else begin
            active_prev_reg <= tx_active;
        end
    end

    // Rising edge means the transmitter has begun, falling edge it stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transmitter_started <= 1'b0;
            transmitter_halted  <= 1'b0;
        end else begin
            transmitter_started <= tx_active & ~active_prev_reg;
            transmitter_halted  <= ~tx_active & active_prev_reg;
        end
    end
endmodule : ues_tx_detect
`default_nettype wire

// File: hdl/ues_rx_fill.sv
`timescale 1ns/10ps
`default_nettype none
module ues_rx_fill (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Byte stored into the receive buffer, buffer size, restart
    input  wire logic        rx_byte_stored,
    input  wire logic [15:0] rx_max_count,
    input  wire logic        restart,
    // Fill state and full pulse
    output logic      [15:0] fill_count,
    output logic             receive_buffer_full
);
    logic [15:0] count_next;   // Count after this byte

    // Next count, never wider than the counter
    always_comb begin
        count_next = 16'(fill_count + 16'h0001);
    end

    // Count bytes; wrap to zero and pulse full when the limit is reached
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_count          <= ues_pkg::CNT_RST;
            receive_buffer_full <= 1'b0;
        end else if (restart) begin
            // A new reception begins with an empty buffer
            fill_count          <= ues_pkg::CNT_RST;
            receive_buffer_full <= 1'b0;
        end else if (rx_byte_stored && rx_max_count != 16'h0000
                     && count_next == rx_max_count) begin
            fill_count          <= ues_pkg::CNT_RST;
            receive_buffer_full <= 1'b1;
        end else begin
            if (rx_byte_stored) begin
                fill_count <= count_next;
            end
            receive_buffer_full <= 1'b0;
        end
    end
endmodule : ues_rx_fill
`default_nettype wire

// File: hdl/ues_top.sv
`timescale 1ns/10ps
`default_nettype none
module ues_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Event pulses from the serial engine, same clock
    input  wire logic        clear_to_send_activated,
    input  wire logic        clear_to_send_deactivated,
    input  wire logic        receive_byte_ready,
    input  wire logic        transmit_byte_sent,
    input  wire logic        last_byte_transmitted,
    input  wire logic        rx_error,
    input  wire logic        receiver_timeout,
    input  wire logic        receiver_started,
    // Receive buffer progress
    input  wire logic        rx_byte_stored,
    input  wire logic [15:0] rx_max_count,
    // Transmitter activity level
    input  wire logic        tx_active,
    // Tasks raised by the shortcuts
    output logic             receiver_start_task,
    output logic             receiver_stop_task,
    // Interrupt
    output logic             irq
);
    // Stored state
    logic [22:0] event_flags_reg;      // One sticky flag per event position
    logic [22:0] event_flags_next;     // Next value of the flags
    logic [31:0] event_task_shortcuts; // Shortcut register
    logic [22:0] interrupt_enable_mask;// Interrupt enable register
    logic [22:0] status_capture_reg;   // Flags captured in the last setup cycle

    // Event sources
    logic [22:0] event_set;            // Hardware set requests this cycle
    logic        transmitter_started;  // Transmitter began
    logic        transmitter_halted;   // Transmitter stopped
    logic        receive_buffer_full;  // Buffer reached its size
    logic [15:0] fill_count;           // Bytes in the current buffer

    // Bus decode
    logic        setup_phase;          // First cycle of a transfer
    logic        access_phase;         // Completing cycle of a transfer
    logic        wr_access;            // Write completes now
    logic        rd_access;            // Read completes now
    logic        hit_event;            // Address is an event flag register
    logic        hit_shortcuts;        // Address is the shortcut register
    logic        hit_enable;           // Address is the enable register
    logic        hit_status;           // Address is the status register
    logic        hit_fill;             // Address is the fill count
    logic        hit_any;              // Any mapped address
    logic [4:0]  event_index;          // Event position from the address
    logic [31:0] read_value;           // Data selected for a read
    logic [22:0] read_clear;           // Flags cleared by a status read
    logic        status_read_pending;  // Status read in its access phase

    // Transmitter start and stop detection
    ues_tx_detect u_tx_detect (
        .pclk                (pclk),
        .presetn             (presetn),
        .tx_active           (tx_active),
        .transmitter_started (transmitter_started),
        .transmitter_halted  (transmitter_halted)
    );

    // Receive buffer fill tracking; a restart task empties it
    ues_rx_fill u_rx_fill (
        .pclk                (pclk),
        .presetn             (presetn),
        .rx_byte_stored      (rx_byte_stored),
        .rx_max_count        (rx_max_count),
        .restart             (receiver_start_task),
        .fill_count          (fill_count),
        .receive_buffer_full (receive_buffer_full)
    );

    // Gather event pulses into their bit positions
    always_comb begin
        event_set = 23'h00_0000;
        event_set[ues_pkg::EV_CTS_ACT]   = clear_to_send_activated;
        event_set[ues_pkg::EV_CTS_DEACT] = clear_to_send_deactivated;
        event_set[ues_pkg::EV_RX_BYTE]   = receive_byte_ready;
        event_set[ues_pkg::EV_RX_FULL]   = receive_buffer_full;
        event_set[ues_pkg::EV_TX_BYTE]   = transmit_byte_sent;
        event_set[ues_pkg::EV_TX_LAST]   = last_byte_transmitted;
        event_set[ues_pkg::EV_ERROR]     = rx_error;
        event_set[ues_pkg::EV_RX_TMO]    = receiver_timeout;
        event_set[ues_pkg::EV_RX_START]  = receiver_started;
        event_set[ues_pkg::EV_TX_START]  = transmitter_started;
        event_set[ues_pkg::EV_TX_HALT]   = transmitter_halted;
    end

    // APB phases; the slave never inserts wait states
    always_comb begin
        setup_phase  = psel & ~penable;
        access_phase = psel & penable;
        wr_access    = access_phase & pwrite;
        rd_access    = access_phase & ~pwrite;
    end

    // Handshake: every access completes in its first access cycle
    always_comb begin
        pready = 1'b1;
    end

    // Address decode; only aligned words are mapped
    always_comb begin
        event_index   = paddr[6:2];
        hit_event     = 1'b0;
        if (paddr[11:7] == ues_pkg::EVT_BASE_OFF[11:7] && paddr[1:0] == 2'b00
            && event_index < 5'(ues_pkg::EVT_W)) begin
            hit_event = ues_pkg::EVT_VALID[event_index];
        end
        hit_shortcuts = (paddr == ues_pkg::SHORTCUTS_OFF);
        hit_enable    = (paddr == ues_pkg::INT_ENABLE_OFF);
        hit_status    = (paddr == ues_pkg::INT_STATUS_OFF);
        hit_fill      = (paddr == ues_pkg::FILL_COUNT_OFF);
        hit_any       = hit_event | hit_shortcuts | hit_enable | hit_status | hit_fill;
    end

    // Read multiplexer; unmapped space and reserved bits read zero
    always_comb begin
        read_value = 32'h0000_0000;
        if (hit_event) begin
            read_value[0] = event_flags_reg[event_index];
        end else if (hit_shortcuts) begin
            read_value = event_task_shortcuts;
        end else if (hit_enable) begin
            read_value = {9'h000, interrupt_enable_mask};
        end else if (hit_status) begin
            read_value = {9'h000, event_flags_reg};
        end else if (hit_fill) begin
            read_value = {16'h0000, fill_count};
        end
    end

    // Read data and error are captured in the setup cycle so they come
    // from flip-flops yet are valid in the single access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata  <= pwrite ? 32'h0000_0000 : read_value;
            pslverr <= ~hit_any;
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

    // Remember which flags a status read showed; only those are cleared,
    // so an event landing between setup and access is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_capture_reg  <= ues_pkg::EVT_RST;
            status_read_pending <= 1'b0;
        end else if (setup_phase) begin
            status_capture_reg  <= event_flags_reg;
            status_read_pending <= hit_status & ~pwrite;
        end else begin
            status_read_pending <= 1'b0;
        end
    end

    // Clear mask applied at the access edge of a status read
    always_comb begin
        read_clear = 23'h00_0000;
        if (rd_access && status_read_pending) begin
            read_clear = status_capture_reg;
        end
    end

    // Per-event next value: hardware set wins over any clear or write
    for (genvar i = 0; i < ues_pkg::EVT_W; i++) begin : g_flag
        if (ues_pkg::EVT_VALID[i]) begin : g_used
            always_comb begin
                if (event_set[i]) begin
                    event_flags_next[i] = 1'b1;
                end else if (wr_access && hit_event && event_index == 5'(i)) begin
                    // Software may write the flag either way
                    event_flags_next[i] = pwdata[0];
                end else begin
                    event_flags_next[i] = event_flags_reg[i] & ~read_clear[i];
                end
            end
        end else begin : g_unused
            // Positions without an event stay zero
            always_comb begin
                event_flags_next[i] = 1'b0;
            end
        end
    end

    // Event flag storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_flags_reg <= ues_pkg::EVT_RST;
        end else begin
            event_flags_reg <= event_flags_next;
        end
    end

    // Shortcut register; undefined positions are not writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_task_shortcuts <= ues_pkg::SC_RST;
        end else if (wr_access && hit_shortcuts) begin
            event_task_shortcuts <= pwdata & ues_pkg::SC_VALID;
        end
    end

    // Interrupt enable register; each defined position is plain read-write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_enable_mask <= ues_pkg::INTERRUPT_ENABLE_MASK_RST;
        end else if (wr_access && hit_enable) begin
            // Clear-to-send pair, receive pair, transmit pair, error, and
            // timeout, receiver start, transmitter start and halt
            interrupt_enable_mask <= pwdata[22:0] & ues_pkg::EVT_VALID;
        end
    end

    // Shortcut tasks, one pulse per buffer-full event; both may fire at
    // once if software enables both, leaving the engine to order them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receiver_start_task <= 1'b0;
            receiver_stop_task  <= 1'b0;
        end else begin
            receiver_start_task <= receive_buffer_full
                                   & event_task_shortcuts[ues_pkg::SC_RESTART];
            receiver_stop_task  <= receive_buffer_full
                                   & event_task_shortcuts[ues_pkg::SC_STOP];
        end
    end

    // Interrupt level, registered so it is glitch free; it trails the
    // flags by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(event_flags_reg & interrupt_enable_mask);
        end
    end
endmodule : ues_top
`default_nettype wire

// File: testbench/ues_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ues_sva (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // Events, tasks and interrupt
    input wire logic        rx_error,
    input wire logic        clear_to_send_deactivated,
    input wire logic        rx_byte_stored,
    input wire logic        tx_active,
    input wire logic        receiver_start_task,
    input wire logic        receiver_stop_task,
    input wire logic        irq
);
    logic [22:0] en_sh;  // Enable mask as software last wrote it
    logic [6:5]  sc_sh;  // Shortcut bits as software last wrote them
    logic        wr_acc; // Write completes here; the bus has no wait states
    assign wr_acc = psel && penable && pwrite;
    // Shadow the two registers from bus writes, since they are not at the ports
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_sh <= 23'h00_0000;
            sc_sh <= 2'h0;
        end else if (wr_acc && paddr == ues_pkg::INT_ENABLE_OFF) begin
            en_sh <= pwdata[22:0];
        end else if (wr_acc && paddr == ues_pkg::SHORTCUTS_OFF) begin
            sc_sh <= pwdata[6:5];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_error_irq : assert property (rx_error && en_sh[9] |-> ##2 irq)
        else $error("irq missing after enabled error event");
    a_cts_irq : assert property (clear_to_send_deactivated && en_sh[1] |-> ##2 irq)
        else $error("irq missing after enabled clear-to-send event");
    // Level to pulse, pulse to flag, flag to irq: three registered steps
    a_txstart_irq : assert property ($rose(tx_active) && en_sh[20] |-> ##3 irq)
        else $error("irq missing after transmitter start");
    a_txhalt_irq : assert property ($fell(tx_active) && en_sh[22] |-> ##3 irq)
        else $error("irq missing after transmitter halt");
    a_mask_blocks : assert property ($past(en_sh) == 23'h00_0000 |-> !irq)
        else $error("irq high with every event masked");
    a_restart_task : assert property (receiver_start_task
        |-> sc_sh[5] && $past(rx_byte_stored, 2))
        else $error("start task without shortcut or full buffer");
    a_stop_task : assert property (receiver_stop_task
        |-> sc_sh[6] && $past(rx_byte_stored, 2))
        else $error("stop task without shortcut or full buffer");
    a_task_pulse : assert property (receiver_start_task || receiver_stop_task
        |=> !receiver_start_task && !receiver_stop_task)
        else $error("shortcut task longer than one cycle");
    a_unmapped_err : assert property (psel && penable
        && (paddr[11] || paddr == 12'h300) |-> pslverr == paddr[11])
        else $error("slave error wrong for mapped or unmapped access");
    c_restart : cover property (receiver_start_task);
    c_stop : cover property (receiver_stop_task);
    c_err_irq : cover property (rx_error && en_sh[9] ##2 irq);
endmodule : ues_sva
bind ues_top ues_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .rx_error(rx_error),
    .clear_to_send_deactivated(clear_to_send_deactivated), .rx_byte_stored(rx_byte_stored),
    .tx_active(tx_active), .receiver_start_task(receiver_start_task),
    .receiver_stop_task(receiver_stop_task), .irq(irq));
`default_nettype wire

// File: testbench/ues_serial_model.sv
`timescale 1ns/10ps
`default_nettype none
module ues_serial_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Requests from the bench, tasks from the block
    input  wire logic [22:0] evt_req,
    input  wire logic        byte_req,
    input  wire logic        start_task,
    input  wire logic        stop_task,
    // Toward the block
    output logic      [22:0] ev,
    output logic             stored,
    output logic             rx_started
);
    logic rx_run; // Receiver running; a stopped receiver drops incoming bytes
    // Receiver follows the block's tasks and answers a start with a started pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_run     <= 1'b1;
            rx_started <= 1'b0;
            ev         <= 23'h00_0000;
            stored     <= 1'b0;
        end else begin
            rx_started <= start_task;
            if (start_task) begin
                rx_run <= 1'b1;
            end else if (stop_task) begin
                rx_run <= 1'b0;
            end
            ev     <= evt_req;
            stored <= byte_req && rx_run;
        end
    end
endmodule : ues_serial_model
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic        rd_e, tx_act, byte_req, stored, rx_started, st_task, sp_task;
    logic [22:0] evt_req, ev;
    logic [15:0] rx_max;
    int          n_mismatch, check_count;
    int          evs[7] = '{0, 1, 2, 7, 8, 9, 17}; // Plain pulse events
    ues_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clear_to_send_activated(ev[0]), .clear_to_send_deactivated(ev[1]),
        .receive_byte_ready(ev[2]), .transmit_byte_sent(ev[7]), .last_byte_transmitted(ev[8]),
        .rx_error(ev[9]), .receiver_timeout(ev[17]), .receiver_started(rx_started),
        .rx_byte_stored(stored), .rx_max_count(rx_max), .tx_active(tx_act),
        .receiver_start_task(st_task), .receiver_stop_task(sp_task), .irq(irq));
    ues_serial_model model (.pclk(pclk), .presetn(presetn), .evt_req(evt_req),
        .byte_req(byte_req), .start_task(st_task), .stop_task(sp_task), .ev(ev),
        .stored(stored), .rx_started(rx_started));
    task automatic finish_test;
        $display("Counts: %0d checks, %0d mismatches", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One bus transfer; the request is held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            finish_test();
        end else begin
            rd_v = prdata;
            rd_e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rd_v, exp);
    endtask : rd
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : tick
    task automatic pulse(input int b);
        @(posedge pclk);
        evt_req <= 23'h00_0001 << b;
        @(posedge pclk);
        evt_req <= 23'h00_0000;
    endtask : pulse
    task automatic send_byte;
        @(posedge pclk);
        byte_req <= 1'b1;
        @(posedge pclk);
        byte_req <= 1'b0;
    endtask : send_byte
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, tx_act, byte_req} = 6'h00;
        {paddr, pwdata, evt_req} = '0;
        rx_max = 16'h0002;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(ues_pkg::TX_HALTED_OFF, 32'h0000_0000, "halted_rst");
        rd(ues_pkg::SHORTCUTS_OFF, 32'h0000_0000, "sc_rst");
        rd(ues_pkg::INT_ENABLE_OFF, 32'h0000_0000, "en_rst");
        rd(ues_pkg::TX_BEGUN_OFF, 32'h0000_0000, "begun_rst");
        wr(ues_pkg::SHORTCUTS_OFF, 32'hffff_ffff);
        rd(ues_pkg::SHORTCUTS_OFF, ues_pkg::SC_VALID, "sc_rw");
        wr(ues_pkg::INT_ENABLE_OFF, 32'hffff_ffff);
        rd(ues_pkg::INT_ENABLE_OFF, {9'h000, ues_pkg::EVT_VALID}, "en_rw");
        apb(1'b0, 12'hc00, 32'h0000_0000);
        chk("unmapped_err", {31'h0, rd_e}, 32'h0000_0001);
        $display("test registers done");
        wr(ues_pkg::SHORTCUTS_OFF, 32'h0000_0000);
        foreach (evs[k]) begin
            wr(ues_pkg::INT_ENABLE_OFF, 32'h0000_0001 << evs[k]);
            pulse(evs[k]);
            tick(3);
            chk("irq_on", {31'h0, irq}, 32'h0000_0001);
            rd(ues_pkg::INT_STATUS_OFF, 32'h0000_0001 << evs[k], "status");
            tick(2);
            chk("irq_off", {31'h0, irq}, 32'h0000_0000);
        end
        // Error masked: flag still sets, interrupt stays low
        wr(ues_pkg::INT_ENABLE_OFF, 32'h0000_0100);
        pulse(9);
        tick(3);
        chk("irq_masked", {31'h0, irq}, 32'h0000_0000);
        rd(12'h124, 32'h0000_0001, "err_flag");
        wr(12'h124, 32'h0000_0000);
        rd(12'h124, 32'h0000_0000, "err_clr");
        $display("test events done");
        wr(ues_pkg::INT_ENABLE_OFF, 32'h0050_0000);
        tx_act <= 1'b1;
        tick(4);
        rd(ues_pkg::TX_BEGUN_OFF, 32'h0000_0001, "tx_begun");
        // Clear the start flag first so the halt alone must raise irq
        rd(ues_pkg::INT_STATUS_OFF, 32'h0010_0000, "tx_start_st");
        tx_act <= 1'b0;
        tick(4);
        chk("irq_halt", {31'h0, irq}, 32'h0000_0001);
        rd(ues_pkg::INT_STATUS_OFF, 32'h0040_0000, "tx_status");
        $display("test transmitter done");
        // Restart shortcut: full buffer restarts the receiver, which reports started
        wr(ues_pkg::INT_ENABLE_OFF, 32'h0000_0000);
        wr(ues_pkg::SHORTCUTS_OFF, 32'h0000_0020);
        send_byte();
        send_byte();
        tick(5);
        rd(ues_pkg::INT_STATUS_OFF, 32'h0008_0010, "restart");
        send_byte();
        tick(2);
        rd(ues_pkg::FILL_COUNT_OFF, 32'h0000_0001, "fill_one");
        // Stop shortcut: after full, the stopped receiver drops the next byte
        wr(ues_pkg::SHORTCUTS_OFF, 32'h0000_0040);
        send_byte();
        tick(4);
        send_byte();
        tick(2);
        rd(ues_pkg::FILL_COUNT_OFF, 32'h0000_0000, "fill_stop");
        rd(ues_pkg::INT_STATUS_OFF, 32'h0000_0010, "stop");
        $display("test buffer done");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
